// File: design/rate_converter.sv
`timescale 1ns/1ps
module rate_converter
	import rate_converter_pkg::*;
#(
	parameter int WINDOW_CYCLES = ACQ_WINDOW_CYCLES, // Acquisition gate
	parameter int WIN_W         = 18,                // Gate counter width
	parameter int CNT_W         = 11,                // Sample count width
	parameter int DLY_DEPTH     = 4                  // Delay line taps
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire flags_s      flow_events,      // Hub flow event pulses
	input  wire logic        in_sample_strobe, // Input sample arrived
	input  wire logic        out_sample_strobe,// Output sample taken
	input  wire logic        out_left_bit,
	input  wire logic        out_right_bit,
	input  wire logic        density_bit_clock,
	input  wire logic        density_data_in,
	output logic             density_data_out,
	output logic             density_out_oe_n,
	output logic             density_in_left,
	output logic             density_in_right,
	output logic             density_in_strobe,
	output cfg_s             cfg,
	output logic      [23:0] in_rate_value,
	output logic             in_rate_load,
	output logic             resync_pulse,
	output logic             in_acquired,
	output logic             out_acquired
);

	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	initial begin
		if (WINDOW_CYCLES < 2 || WINDOW_CYCLES >= (1 << WIN_W))
			$error("WINDOW_CYCLES does not fit the gate counter");
		if (CNT_W + RATE_SHIFT > 24)
			$error("CNT_W too wide for the rate value");
		if (delay_cycles(OUT_DLY_NS[3]) > DLY_DEPTH ||
		    delay_cycles(IN_DLY_NS[3]) > DLY_DEPTH)
			$error("DLY_DEPTH too short for the delay codes");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		cfg_s                 cfg;        // Software settings
		flags_s               flags;      // Sticky flow flags
		logic                 out_clear;  // Held output flow clear
		logic                 in_clear;   // Held input flow clear
		logic [23:0]          in_rate;    // Input rate register
		acq_e                 in_acq;
		acq_e                 out_acq;
		logic [WIN_W-1:0]     in_win;     // Gate countdown
		logic [WIN_W-1:0]     out_win;
		logic [CNT_W-1:0]     in_cnt;     // Samples inside gate
		logic                 out_seen;   // Any output sample in gate
		logic                 in_ok;
		logic                 out_ok;
		logic                 rate_load;
		logic                 resync;
		logic [31:0]          prdata;
		logic                 pready;
		logic                 pslverr;
		logic                 clk_meta;   // Synchroniser first stage
		logic                 clk_sync;
		logic                 clk_prev;
		logic                 din_meta;   // Synchroniser first stage
		logic                 din_sync;
		logic [DLY_DEPTH-1:0] din_line;
		logic [DLY_DEPTH-1:0] dout_line;
		logic                 dout_pre;   // Bit picked at the edge
		logic                 dout;
		logic                 oe_n;
		logic                 in_left;
		logic                 in_right;
		logic                 in_strobe;
	} state_s;

	state_s s;      // Registered state
	state_s next_s; // Next state

	// Tap of a delay line for a delay in nanoseconds
	function automatic logic tap(input logic [DLY_DEPTH-1:0] line,
	                             input logic now, input int ns);
		int c;
		c = delay_cycles(ns);
		if (c == 0)
			return now;
		return line[c-1];
	endfunction : tap

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic                 setup;
		logic                 access;
		logic                 wr_ctrl;
		logic                 wr_rate;
		logic                 out_clr_now;
		logic                 in_clr_now;
		logic                 rise;
		logic                 fall;
		logic                 din_tap;
		logic                 in_go;
		logic                 out_go;
		logic [CNT_W-1:0]     cnt_one;
		logic [31:0]          rd;
		setup       = psel && !penable;
		access      = psel && penable && s.pready;
		wr_ctrl     = access && pwrite && paddr == CTRL_ADDR;
		wr_rate     = access && pwrite && paddr == IN_RATE_ADDR;
		out_clr_now = 1'b0;
		in_clr_now  = 1'b0;
		rise        = s.clk_sync && !s.clk_prev;
		fall        = !s.clk_sync && s.clk_prev;
		din_tap     = 1'b0;
		in_go       = 1'b0;
		out_go      = 1'b0;
		cnt_one     = CNT_W'(1);
		rd          = 32'h0000_0000;
		next_s      = s;
		next_s.rate_load = 1'b0;
		next_s.resync    = 1'b0;
		next_s.in_strobe = 1'b0;

		// Software writes to the control register
		if (wr_ctrl) begin
			next_s.cfg.density_out_delay = pwdata[OUT_DLY_LSB +: 2]; // R1
			next_s.cfg.density_out_mode  = pwdata[MODE_LSB +: 2];    // R2
			next_s.cfg.density_in_delay  = pwdata[IN_DLY_LSB +: 2];  // R3
			next_s.out_clear = pwdata[OUT_CLR_BIT];                  // R4
			next_s.in_clear  = pwdata[IN_CLR_BIT];                   // R5
			next_s.resync    = pwdata[RESYNC_BIT];                   // R8
			// Reserved range code is refused, old setting kept
			if (pwdata[OUT_RANGE_LSB +: 2] != RANGE_RSVD) begin
				next_s.cfg.out_filter_range =
					pwdata[OUT_RANGE_LSB +: 2];                      // R10
			end
			if (pwdata[IN_RANGE_LSB +: 2] != RANGE_RSVD) begin
				next_s.cfg.in_filter_range =
					pwdata[IN_RANGE_LSB +: 2];                       // R15
			end
			next_s.cfg.out_filter_bypass = pwdata[OUT_BYP_BIT];      // R11
			next_s.cfg.in_filter_bypass  = pwdata[IN_BYP_BIT];       // R11
			next_s.cfg.out_auto_mode     = pwdata[OUT_AUTO_BIT];     // R12
			next_s.cfg.dither_off        = pwdata[DITHER_BIT];       // R13
			next_s.cfg.in_auto_mode      = pwdata[IN_AUTO_BIT];      // R16
			next_s.cfg.converter_enable  = pwdata[ENABLE_BIT];       // R17
		end

		// Rate writes are taken and pushed at once, except in the cycle the input gate closes
		if (wr_rate) begin
			next_s.in_rate   = pwdata[23:0]; // R18
			next_s.rate_load = 1'b1;         // R20
		end

		// Flow flags: a held clear wins and blocks new events
		out_clr_now = wr_ctrl ? pwdata[OUT_CLR_BIT] : s.out_clear;
		in_clr_now  = wr_ctrl ? pwdata[IN_CLR_BIT] : s.in_clear;
		if (out_clr_now) begin
			next_s.flags.out_underflow_flag = 1'b0; // R4
			next_s.flags.out_overflow_flag  = 1'b0; // R4
		end else begin
			next_s.flags.out_underflow_flag = s.flags.out_underflow_flag ||
				flow_events.out_underflow_flag;      // R23
			next_s.flags.out_overflow_flag  = s.flags.out_overflow_flag ||
				flow_events.out_overflow_flag;       // R23
		end
		if (in_clr_now) begin
			next_s.flags.in_underflow_flag = 1'b0;  // R5
			next_s.flags.in_overflow_flag  = 1'b0;  // R5
		end else begin
			next_s.flags.in_underflow_flag = s.flags.in_underflow_flag ||
				flow_events.in_underflow_flag;       // R23
			next_s.flags.in_overflow_flag  = s.flags.in_overflow_flag ||
				flow_events.in_overflow_flag;        // R23
		end

		// Input acquisition: count samples inside a fixed gate
		in_go = next_s.cfg.converter_enable && next_s.cfg.in_auto_mode;
		if (!in_go) begin
			next_s.in_acq = ACQ_IDLE; // R16
		end else if (next_s.resync || s.in_acq == ACQ_IDLE) begin
			next_s.in_acq = ACQ_RUN;  // R8
			next_s.in_win = WIN_W'(WINDOW_CYCLES - 1);
			next_s.in_cnt = '0;
		end else begin
			case (s.in_acq)
				ACQ_RUN: begin
					// Count saturates rather than wrap on a wild rate
					if (in_sample_strobe && s.in_cnt != '1)
						next_s.in_cnt = s.in_cnt + cnt_one;
					if (s.in_win == '0) begin
						next_s.in_acq    = ACQ_READY;
						next_s.in_rate   = 24'({next_s.in_cnt,
						                        RATE_SHIFT'(0)}); // R21
						next_s.rate_load = 1'b1;                  // R21
					end else begin
						next_s.in_win = s.in_win - WIN_W'(1);
					end
				end
				default: begin
					next_s.in_acq = s.in_acq;
				end
			endcase
		end

		// Output acquisition: ready after a gate that saw samples
		out_go = next_s.cfg.converter_enable && next_s.cfg.out_auto_mode;
		if (!out_go) begin
			next_s.out_acq = ACQ_IDLE; // R12
		end else if (next_s.resync || s.out_acq == ACQ_IDLE) begin
			next_s.out_acq  = ACQ_RUN; // R8
			next_s.out_win  = WIN_W'(WINDOW_CYCLES - 1);
			next_s.out_seen = 1'b0;
		end else begin
			case (s.out_acq)
				ACQ_RUN: begin
					if (out_sample_strobe)
						next_s.out_seen = 1'b1;
					if (s.out_win != '0) begin
						next_s.out_win = s.out_win - WIN_W'(1);
					end else if (next_s.out_seen) begin
						next_s.out_acq = ACQ_READY;
					end else begin
						// No samples yet: gate again
						next_s.out_win = WIN_W'(WINDOW_CYCLES - 1);
					end
				end
				default: begin
					next_s.out_acq = s.out_acq;
				end
			endcase
		end

		// Ready flags; manual mode always reports ready
		next_s.out_ok = !next_s.cfg.out_auto_mode ||
		                next_s.out_acq == ACQ_READY;              // R9
		next_s.in_ok  = !next_s.cfg.in_auto_mode ||
		                next_s.in_acq == ACQ_READY;               // R14

		// Pin synchronisers and edge detection of the bit clock
		next_s.clk_meta = density_bit_clock;
		next_s.clk_sync = s.clk_meta;
		next_s.clk_prev = s.clk_sync;
		next_s.din_meta = density_data_in;
		next_s.din_sync = s.din_meta;

		// Input delay line, then sample per edge
		next_s.din_line = {s.din_line[DLY_DEPTH-2:0], s.din_sync};
		din_tap = tap(s.din_line, s.din_sync,
		              IN_DLY_NS[s.cfg.density_in_delay]);        // R3
		if (s.cfg.converter_enable && rise)
			next_s.in_left = din_tap;
		if (s.cfg.converter_enable && fall) begin
			next_s.in_right  = din_tap;
			next_s.in_strobe = 1'b1;
		end

		// Output bit chosen on the edge that the mode asks for
		if (rise && s.cfg.density_out_mode[1])
			next_s.dout_pre = out_left_bit;                      // R2
		if (fall && s.cfg.density_out_mode[0])
			next_s.dout_pre = out_right_bit;                     // R2
		next_s.dout_line = {s.dout_line[DLY_DEPTH-2:0], s.dout_pre};
		next_s.dout = tap(s.dout_line, s.dout_pre,
		                  OUT_DLY_NS[s.cfg.density_out_delay]);  // R1
		next_s.oe_n = !(s.cfg.converter_enable &&
		                s.cfg.density_out_mode != DENS_OFF);     // R2

		// APB: answer prepared in setup, ready in the access cycle
		next_s.pready  = setup;
		next_s.pslverr = 1'b0;
		if (setup) begin
			if (paddr == CTRL_ADDR) begin
				rd[OUT_DLY_LSB +: 2]   = s.cfg.density_out_delay;
				rd[MODE_LSB +: 2]      = s.cfg.density_out_mode;
				rd[IN_DLY_LSB +: 2]    = s.cfg.density_in_delay;
				rd[FLAGS_LSB +: 4]     = s.flags;                // R7
				rd[RESYNC_BIT]         = 1'b0;                   // R8
				rd[OUT_OK_BIT]         = s.out_ok;               // R9
				rd[OUT_RANGE_LSB +: 2] = s.cfg.out_filter_range;
				rd[OUT_BYP_BIT]        = s.cfg.out_filter_bypass;
				rd[OUT_AUTO_BIT]       = s.cfg.out_auto_mode;
				rd[DITHER_BIT]         = s.cfg.dither_off;
				rd[IN_OK_BIT]          = s.in_ok;                // R14
				rd[IN_RANGE_LSB +: 2]  = s.cfg.in_filter_range;
				rd[IN_BYP_BIT]         = s.cfg.in_filter_bypass;
				rd[IN_AUTO_BIT]        = s.cfg.in_auto_mode;
				rd[ENABLE_BIT]         = s.cfg.converter_enable;
			end else if (paddr == IN_RATE_ADDR) begin
				rd[23:0] = s.in_rate;                            // R18
			end else begin
				// Unmapped: error answer, no effect
				next_s.pslverr = 1'b1;
			end
			next_s.prdata = rd;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s         <= '0;
			s.in_rate <= IN_RATE_RESET;
			s.oe_n    <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign prdata            = s.prdata;
	assign pready            = s.pready;
	assign pslverr           = s.pslverr;
	assign density_data_out  = s.dout;
	assign density_out_oe_n  = s.oe_n;
	assign density_in_left   = s.in_left;
	assign density_in_right  = s.in_right;
	assign density_in_strobe = s.in_strobe;
	assign cfg               = s.cfg;
	assign in_rate_value     = s.in_rate;
	assign in_rate_load      = s.rate_load;
	assign resync_pulse      = s.resync;
	assign in_acquired       = s.in_ok;
	assign out_acquired      = s.out_ok;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence ctrl_write;
		psel && penable && pready && pwrite && paddr == CTRL_ADDR;
	endsequence
	sequence ctrl_read;
		psel && penable && !pwrite && paddr == CTRL_ADDR;
	endsequence

	a_out_clear_wins: assert property ( // R4
		s.out_clear |=> !s.flags.out_underflow_flag &&
		                !s.flags.out_overflow_flag)
		else $error("output flags raised under held clear");
	a_in_clear_wins: assert property ( // R5
		s.in_clear |=> !s.flags.in_underflow_flag &&
		               !s.flags.in_overflow_flag)
		else $error("input flags raised under held clear");
	a_flags_sticky: assert property ( // R23
		s.flags.in_overflow_flag && !s.in_clear &&
		!(psel && penable && pready && pwrite && paddr == CTRL_ADDR)
		|=> s.flags.in_overflow_flag)
		else $error("input overflow flag dropped without clear");
	a_flag_readback: assert property ( // R7
		ctrl_read |-> prdata[FLAGS_LSB +: 4] == $past(s.flags))
		else $error("flags misplaced in read data");
	a_resync_zero: assert property ( // R8
		ctrl_read |-> !prdata[RESYNC_BIT])
		else $error("resynchronise bit read as one");
	a_resync_restart: assert property ( // R8
		ctrl_write ##0 (pwdata[RESYNC_BIT] && pwdata[ENABLE_BIT] &&
		                pwdata[IN_AUTO_BIT]) |=> !in_acquired [*2])
		else $error("resynchronise did not restart acquisition");
	a_out_ok_manual: assert property ( // R9
		$past(presetn) && !s.cfg.out_auto_mode |-> out_acquired)
		else $error("output ready low in manual mode");
	a_range_reserved: assert property ( // R10
		ctrl_write |=> s.cfg.out_filter_range != RANGE_RSVD &&
		               s.cfg.in_filter_range != RANGE_RSVD)
		else $error("reserved filter range stored");
	a_manual_rate: assert property ( // R20
		psel && penable && pready && pwrite && paddr == IN_RATE_ADDR
		|=> in_rate_load && in_rate_value == $past(pwdata[23:0]))
		else $error("rate write not taken at once");
	a_auto_rate: assert property ( // R21
		$rose(in_acquired) && s.cfg.in_auto_mode |->
		in_rate_load && in_rate_value[RATE_SHIFT-1:0] == '0)
		else $error("measured rate not stored when ready");
	a_enable_out: assert property ( // R17
		ctrl_write |=> cfg.converter_enable == $past(pwdata[ENABLE_BIT]))
		else $error("enable bit not applied");
	a_oe_by_mode: assert property ( // R2
		1'b1 |=> density_out_oe_n == $past(!(s.cfg.converter_enable &&
		                  s.cfg.density_out_mode != DENS_OFF)))
		else $error("density output enable wrong for mode");
	a_out_no_delay: assert property ( // R1
		s.cfg.density_out_delay == 2'h0 && $stable(s.cfg)
		|=> density_data_out == $past(s.dout_pre))
		else $error("undelayed density output mismatch");

endmodule : rate_converter

// File: design/rate_converter_pkg.sv
// Behaviour
// R1: Output density delay codes 0,14,20,26 ns
// R2: Density mode: off, right fall, left rise, both
// R3: Input density delay codes 0,6,12,18 ns
// R4: Output flow clear clears, blocks output flags
// R5: Input flow clear clears, blocks input flags
// R6: Software holds clear until flags read cleared
// R7: Flags at bits 23..20 read one on event
// R8: Resynchronise restarts acquisition, reads back zero
// R9: Output ready zero acquiring, one manual mode
// R10: Output filter range 48/96/192k, 10 reserved
// R11: Bypass bits skip each path's upsampling filter
// R12: Output auto mode bit: manual or automatic
// R13: Dither bit zero enables, one disables dithering
// R14: Input ready zero acquiring, one when ready
// R15: Input filter range 48/96/192k, 10 reserved
// R16: Input auto mode bit: manual or automatic
// R17: One enable bit switches both paths
// R18: Input rate value is 8192 times rate/100
// R19: Software keeps rate at most 192k, range matched
// R20: Manual mode takes rate writes immediately
// R21: Auto mode stores measured rate when ready
// R22: Software sets filter range itself in auto mode
// R23: Flow flags stay set until cleared
package rate_converter_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [31:0] CTRL_ADDR     = 32'h5000_4000;
	localparam logic [31:0] IN_RATE_ADDR  = 32'h5000_4004;
	localparam logic [23:0] IN_RATE_RESET = 24'h00_0000;

	// Control register field positions
	localparam int OUT_DLY_LSB   = 30;
	localparam int MODE_LSB      = 28;
	localparam int IN_DLY_LSB    = 26;
	localparam int OUT_CLR_BIT   = 25;
	localparam int IN_CLR_BIT    = 24;
	localparam int FLAGS_LSB     = 20;
	localparam int RESYNC_BIT    = 19;
	localparam int OUT_OK_BIT    = 18;
	localparam int OUT_RANGE_LSB = 16;
	localparam int OUT_BYP_BIT   = 14;
	localparam int OUT_AUTO_BIT  = 13;
	localparam int DITHER_BIT    = 7;
	localparam int IN_OK_BIT     = 6;
	localparam int IN_RANGE_LSB  = 4;
	localparam int IN_BYP_BIT    = 2;
	localparam int IN_AUTO_BIT   = 1;
	localparam int ENABLE_BIT    = 0;

	// ------------------------------------------------------------
	// Codes
	// ------------------------------------------------------------
	localparam logic [1:0] DENS_OFF   = 2'h0;
	localparam logic [1:0] DENS_RIGHT = 2'h1;
	localparam logic [1:0] DENS_LEFT  = 2'h2;
	localparam logic [1:0] DENS_BOTH  = 2'h3;
	localparam logic [1:0] RANGE_48K  = 2'h0;
	localparam logic [1:0] RANGE_96K  = 2'h1;
	localparam logic [1:0] RANGE_RSVD = 2'h2;
	localparam logic [1:0] RANGE_192K = 2'h3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ        = 20_000_000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int OUT_DLY_NS [4] = '{0, 14, 20, 26};
	localparam int IN_DLY_NS  [4] = '{0, 6, 12, 18};
	// Acquisition gate: one count per 100 Hz of sample rate
	localparam int ACQ_WINDOW_MS     = 10;
	localparam int ACQ_WINDOW_CYCLES = CLK_HZ / 1000 * ACQ_WINDOW_MS;
	// 8192 * (count * 100) / 100 = count << 13
	localparam int RATE_SHIFT        = 13;

	// Least delay rounds up to whole cycles, zero ns gives zero cycles
	function automatic int delay_cycles(input int ns);
		return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction : delay_cycles

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {ACQ_IDLE, ACQ_RUN, ACQ_READY} acq_e;

	typedef struct packed {
		logic [1:0] density_out_delay;
		logic [1:0] density_out_mode;
		logic [1:0] density_in_delay;
		logic [1:0] out_filter_range;
		logic       out_filter_bypass;
		logic       out_auto_mode;
		logic       dither_off;
		logic [1:0] in_filter_range;
		logic       in_filter_bypass;
		logic       in_auto_mode;
		logic       converter_enable;
	} cfg_s;

	typedef struct packed {
		logic out_underflow_flag;
		logic out_overflow_flag;
		logic in_underflow_flag;
		logic in_overflow_flag;
	} flags_s;

endpackage : rate_converter_pkg

// File: verif/hub_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Audio hub stand-in: flow events, sample pacing, density link
// ------------------------------------------------------------
module hub_model
	import rate_converter_pkg::*;
(
	input  wire logic pclk,
	output flags_s    flow_events,
	output logic      in_sample_strobe,
	output logic      out_sample_strobe,
	output logic      out_left_bit,
	output logic      out_right_bit,
	output logic      density_bit_clock,
	output logic      density_data_in
);
	logic [2:0] phase = 3'h0; // Paces one sample every 8 clocks

	initial begin
		flow_events = '0;
		out_left_bit = 1'b0;
		out_right_bit = 1'b0;
		density_bit_clock = 1'b0; // Link clock still outside frames
		density_data_in = 1'b0;
	end

	// Steady pace keeps the measured count independent of phase
	always @(posedge pclk) begin
		phase <= phase + 3'h1;
	end
	assign in_sample_strobe  = (phase == 3'h0);
	assign out_sample_strobe = (phase == 3'h4);

	// One-cycle flow event pulse
	task pulse(input flags_s f);
		@(posedge pclk);
		flow_events <= f;
		@(posedge pclk);
		flow_events <= '0;
	endtask : pulse

	// Eight bit clocks of 400 ns; line shows inverse once released
	task frame(input logic v);
		@(posedge pclk);
		out_left_bit  <= v;  // Left and right differ so the mode shows
		out_right_bit <= ~v;
		#13;
		repeat (8) begin
			density_data_in = v;
			#200 density_bit_clock = 1'b1;
			#200 density_bit_clock = 1'b0;
		end
		#200 density_data_in = ~v;
	endtask : frame
endmodule : hub_model

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import rate_converter_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, sh, d;
	flags_s      flow_events;
	logic        in_ss, out_ss, ol, orr, dclk, ddi, oe_n, dl, dr;
	logic        resync_pulse, in_acquired, out_acquired;
	logic        dout, dstb, rload;
	cfg_s        cfg;
	logic [23:0] in_rate_value;
	logic [32:0] exp_q[$];  // Expected {pslverr, prdata} per read
	logic [32:0] e;
	int          bad_count = 0, cmp_count = 0, n, n_stb = 0;

	hub_model u_hub (.pclk(pclk), .flow_events(flow_events),
		.in_sample_strobe(in_ss), .out_sample_strobe(out_ss),
		.out_left_bit(ol), .out_right_bit(orr),
		.density_bit_clock(dclk), .density_data_in(ddi));

	rate_converter #(.WINDOW_CYCLES(64)) u_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flow_events(flow_events), .in_sample_strobe(in_ss),
		.out_sample_strobe(out_ss), .out_left_bit(ol),
		.out_right_bit(orr), .density_bit_clock(dclk),
		.density_data_in(ddi), .density_data_out(dout),
		.density_out_oe_n(oe_n), .density_in_left(dl),
		.density_in_right(dr), .density_in_strobe(dstb), .cfg(cfg),
		.in_rate_value(in_rate_value), .in_rate_load(rload),
		.resync_pulse(resync_pulse), .in_acquired(in_acquired),
		.out_acquired(out_acquired));

	// ------------------------------------------------------------
	// Clock, comparison and verdict
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic check(input logic [32:0] seen, input logic [32:0] ex);
		cmp_count++;
		if (seen !== ex) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, ex);
		end
	endtask : check

	task tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	// APB transfer; request held until pready is sampled high
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{psel, penable} <= 2'b00;
	endtask : apb

	task rd(input logic [31:0] a, input logic [32:0] ex);
		exp_q.push_back(ex);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd

	// Read results taken off the queue as they appear
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			e = exp_q.pop_front();
			check({pslverr, prdata}, e);
		end
	end

	// Right-bit captures, one strobe per bit clock fall
	always @(posedge pclk) begin
		if (dstb === 1'b1)
			n_stb <= n_stb + 1;
	end

	initial begin
		#500us;
		bad_count++;
		tally_and_finish();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		void'($urandom(32'hA54A4199));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(CTRL_ADDR, 33'h0_0004_0040);
		rd(IN_RATE_ADDR, 33'h0);
		rd(32'h5000_4008, 33'h1_0000_0000);
		sh = 32'h0;
		// Every range code, reserved one refused; auto bits kept off
		for (int i = 0; i < 8; i++) begin
			d = ($urandom & ~32'h0003_2032) | ((i % 4) << 16) | ((i % 4) << 4);
			apb(1'b1, CTRL_ADDR, d);
			sh = (i % 4 == 2) ? (d & 32'hFC03_40B5 & ~32'h0003_0030)
				| (sh & 32'h0003_0030) : (d & 32'hFC03_40B5);
			rd(CTRL_ADDR, {1'b0, sh | 32'h0004_0040});
			check(cfg, {sh[31:26], sh[17:16], sh[14:13], sh[7], sh[5:4], sh[2:0]});
		end
		d = $urandom % 32'h00F0_0001; // Rate kept at 192k or below
		apb(1'b1, IN_RATE_ADDR, d);
		@(posedge pclk);
		check({rload, in_rate_value}, {1'b1, d[23:0]});
		rd(IN_RATE_ADDR, {9'h0, d[23:0]});
		sh = 32'h0000_0001;
		apb(1'b1, CTRL_ADDR, sh);
		u_hub.pulse(4'hF);
		rd(CTRL_ADDR, {1'b0, sh | 32'h00F4_0040});
		apb(1'b1, CTRL_ADDR, sh | 32'h0200_0000);
		u_hub.pulse(4'hF);
		rd(CTRL_ADDR, {1'b0, sh | 32'h0034_0040});
		apb(1'b1, CTRL_ADDR, sh | 32'h0100_0000);
		u_hub.pulse(4'hF);
		rd(CTRL_ADDR, {1'b0, sh | 32'h00C4_0040});
		apb(1'b1, CTRL_ADDR, sh);
		u_hub.pulse(4'h1);
		rd(CTRL_ADDR, {1'b0, sh | 32'h00D4_0040});
		apb(1'b1, CTRL_ADDR, sh | 32'h0008_0000);
		for (n = 0; n < 4 && resync_pulse !== 1'b1; n++) @(posedge pclk);
		check(resync_pulse, 1'b1);
		apb(1'b1, CTRL_ADDR, 32'h3000_0001);
		repeat (2) @(posedge pclk);
		check(oe_n, 1'b0);
		u_hub.frame(1'b1);
		check({dl, dr, dout}, 3'b110);
		u_hub.frame(1'b0);
		check({dl, dr, dout}, 3'b001);
		// Left only, longest delays: falls must not touch the output
		apb(1'b1, CTRL_ADDR, 32'hEC00_0001);
		u_hub.frame(1'b0);
		check({dl, dr, dout}, 3'b000);
		check(n_stb, 24);
		apb(1'b1, CTRL_ADDR, 32'h0000_2003);
		@(posedge pclk);
		check({in_acquired, out_acquired}, 2'b00);
		for (n = 0; n < 400 && in_acquired !== 1'b1; n++) @(posedge pclk);
		check({rload, in_rate_value}, {1'b1, 24'h01_0000});
		for (n = 0; n < 400 && out_acquired !== 1'b1; n++) @(posedge pclk);
		check({in_acquired, out_acquired}, 2'b11);
		apb(1'b1, CTRL_ADDR, 32'h0008_2003);
		@(posedge pclk);
		check({in_acquired, out_acquired}, 2'b00);
		for (n = 0; n < 400 && in_acquired !== 1'b1; n++) @(posedge pclk);
		check({rload, in_rate_value}, {1'b1, 24'h01_0000});
		rd(IN_RATE_ADDR, 33'h0_0001_0000);
		apb(1'b1, CTRL_ADDR, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		check({oe_n, in_acquired, out_acquired}, 3'b111);
		tally_and_finish();
	end
endmodule : tb_top
